// >>> src/tsmi_counter.sv
`timescale 1ns/1ps

// ****************************************
// Channel 0 up counter with period compare
// ****************************************
module tsmi_counter #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic clear_on_match_i,
  input wire logic [CNT_W-1:0] period_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] load_val_i,
  output logic [CNT_W-1:0] count_o,
  output logic match_o
);

  logic [CNT_W-1:0] count_ff;
  logic match_ff;
  logic equal;

  assign equal = (count_ff == period_i);

  // Count only while running; a stopped counter holds its value unless loaded
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= '0;
    end else if (load_i) begin
      count_ff <= load_val_i;
    end else if (run_i) begin
      if (equal && clear_on_match_i) begin
        count_ff <= '0;
      end else begin
        count_ff <= count_ff + CNT_W'(1);
      end
    end
  end

  // One pulse per compare match while counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= run_i && equal && !load_i;
    end
  end

  assign count_o = count_ff;
  assign match_o = match_ff;

endmodule

// >>> src/tsmi_pkg.sv
package tsmi_pkg;

  // ****************************************
  // Bus, register, counter and port widths
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned COUNTER_CLEAR_SELECT_W = 3;
  localparam int unsigned START_W = 4;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_PORT1_DIRECTION = 8'h00;
  localparam logic [7:0] OFS_TIMER0_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_REQUEST_2H = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK_2H = 8'h0c;
  localparam logic [7:0] OFS_TIMER_START = 8'h10;
  localparam logic [7:0] OFS_PERIOD_GENERAL = 8'h14;
  localparam logic [7:0] OFS_COUNTER0 = 8'h18;
  localparam logic [7:0] OFS_TIMER0_CONTROL = 8'h1c;
  localparam logic [7:0] OFS_TIMER0_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFS_PORT1_DATA = 8'h24;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned BIT_PERIOD_MATCH_FLAG = 0;
  localparam int unsigned BIT_TIMER0_IRQ_REQUEST = 1;
  localparam int unsigned BIT_TIMER0_IRQ_MASK = 1;
  localparam int unsigned BIT_COUNTER0_RUN = 0;
  localparam int unsigned BIT_PERIOD_MATCH_IRQ_ENABLE = 0;
  localparam int unsigned BIT_COUNTER_CLEAR_SELECT_LO = 5;
  localparam int unsigned BIT_COUNTER_CLEAR_SELECT_HI = 7;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [2:0] COUNTER_CLEAR_SELECT_ON_PERIOD_MATCH = 3'h1;
  localparam logic [7:0] RST_PORT1_DIRECTION = 8'hff;
  localparam logic [7:0] RST_IRQ_REQUEST_2H = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK_2H = 8'hff;
  localparam logic [3:0] RST_TIMER_START = 4'h0;
  localparam logic [15:0] RST_PERIOD_GENERAL = 16'hffff;
  localparam logic [7:0] RST_TIMER0_CONTROL = 8'h00;
  localparam logic [7:0] RST_PORT1_DATA = 8'h00;

endpackage

// >>> src/tsmi_top.sv
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps

module tsmi_top #(
  parameter int unsigned CNT_W = tsmi_pkg::CNT_W,
  parameter int unsigned PORT_W = tsmi_pkg::PORT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tsmi_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [tsmi_pkg::DATA_W-1:0] wb_dat_i,
  output logic [tsmi_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [PORT_W-1:0] port1_pin_i,
  output logic [PORT_W-1:0] port1_pin_o,
  output logic [PORT_W-1:0] port1_pin_oe_n_o,
  output logic timer0_interrupt_o,
  output logic [CNT_W-1:0] counter0_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic ack_ff;
  logic [tsmi_pkg::DATA_W-1:0] rdata_ff;
  logic [tsmi_pkg::DATA_W-1:0] nxt_rdata;
  logic req;
  logic fire;
  logic wr;
  logic rd;
  logic lane0;
  logic [tsmi_pkg::REG_W-1:0] wbyte;

  logic [PORT_W-1:0] port1_direction_ff;
  logic [PORT_W-1:0] port1_data_ff;
  logic [PORT_W-1:0] pin_s1_ff;
  logic [PORT_W-1:0] pin_s2_ff;
  logic [PORT_W-1:0] pin_s3_ff;
  logic [PORT_W-1:0] pin_level_ff;

  logic period_match_flag_ff;
  logic clear_armed_ff;
  logic [tsmi_pkg::REG_W-1:0] irq_request_flags_2h_ff;
  logic [tsmi_pkg::REG_W-1:0] irq_mask_flags_2h_ff;
  logic [tsmi_pkg::START_W-1:0] timer_start_control_ff;
  logic [CNT_W-1:0] period_general_reg_ff;
  logic [tsmi_pkg::REG_W-1:0] timer0_control_ff;
  logic period_match_irq_enable_ff;

  logic [CNT_W-1:0] counter0;
  logic period_match;
  logic counter0_run;
  logic clear_on_match;
  logic counter0_load;
  logic period_match_interrupt;

  logic wr_status;
  logic wr_request;

  // ****************************************
  // Wishbone classic slave
  // ****************************************
  // Ack comes one cycle after the request; the write happens on the edge where ack is seen,
  // the read arm on the capture edge before it; a held request is acked again every second cycle.
  assign req = wb_cyc_i && wb_stb_i;
  assign fire = req && ack_ff;
  assign wr = fire && wb_we_i;
  assign rd = fire && !wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign wbyte = wb_dat_i[tsmi_pkg::REG_W-1:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // Unmapped offsets read as zero and ignore writes
  always_comb begin
    nxt_rdata = '0;
    if (wb_adr_i == tsmi_pkg::OFS_PORT1_DIRECTION) begin
      nxt_rdata[PORT_W-1:0] = port1_direction_ff;
    end else if (wb_adr_i == tsmi_pkg::OFS_TIMER0_STATUS) begin
      nxt_rdata[tsmi_pkg::BIT_PERIOD_MATCH_FLAG] = period_match_flag_ff;
    end else if (wb_adr_i == tsmi_pkg::OFS_IRQ_REQUEST_2H) begin
      nxt_rdata[tsmi_pkg::REG_W-1:0] = irq_request_flags_2h_ff;
    end else if (wb_adr_i == tsmi_pkg::OFS_IRQ_MASK_2H) begin
      nxt_rdata[tsmi_pkg::REG_W-1:0] = irq_mask_flags_2h_ff;
    end else if (wb_adr_i == tsmi_pkg::OFS_TIMER_START) begin
      nxt_rdata[tsmi_pkg::START_W-1:0] = timer_start_control_ff;
    end else if (wb_adr_i == tsmi_pkg::OFS_PERIOD_GENERAL) begin
      nxt_rdata[CNT_W-1:0] = period_general_reg_ff;
    end else if (wb_adr_i == tsmi_pkg::OFS_COUNTER0) begin
      nxt_rdata[CNT_W-1:0] = counter0;
    end else if (wb_adr_i == tsmi_pkg::OFS_TIMER0_CONTROL) begin
      nxt_rdata[tsmi_pkg::REG_W-1:0] = timer0_control_ff;
    end else if (wb_adr_i == tsmi_pkg::OFS_TIMER0_IRQ_ENABLE) begin
      nxt_rdata[tsmi_pkg::BIT_PERIOD_MATCH_IRQ_ENABLE] =
        period_match_irq_enable_ff;
    end else if (wb_adr_i == tsmi_pkg::OFS_PORT1_DATA) begin
      nxt_rdata[PORT_W-1:0] = pin_level_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else if (req && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ****************************************
  // Port 1 pins
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port1_direction_ff <= tsmi_pkg::RST_PORT1_DIRECTION;
    end else if (wr && lane0 &&
                 wb_adr_i == tsmi_pkg::OFS_PORT1_DIRECTION) begin
      port1_direction_ff <= wbyte[PORT_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port1_data_ff <= tsmi_pkg::RST_PORT1_DATA;
    end else if (wr && lane0 && wb_adr_i == tsmi_pkg::OFS_PORT1_DATA) begin
      port1_data_ff <= wbyte[PORT_W-1:0];
    end
  end

  // Three stages; a change counts only once stages two and three agree,
  // which rejects a single-cycle glitch at the cost of a cycle of latency.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= port1_pin_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Per pin: driven pins read back their latch, others the filtered input
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_level_ff[i] <= 1'b0;
      end else if (!port1_direction_ff[i]) begin
        pin_level_ff[i] <= port1_data_ff[i];
      end else if (pin_s2_ff[i] == pin_s3_ff[i]) begin
        pin_level_ff[i] <= pin_s3_ff[i];
      end
    end
    // Output buffer on when the direction bit is 0
    assign port1_pin_oe_n_o[i] = port1_direction_ff[i];
  end

  assign port1_pin_o = port1_data_ff;

  // ****************************************
  // Timer control registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_start_control_ff <= tsmi_pkg::RST_TIMER_START;
    end else if (wr && lane0 && wb_adr_i == tsmi_pkg::OFS_TIMER_START) begin
      timer_start_control_ff <= wbyte[tsmi_pkg::START_W-1:0];
    end
  end

  assign counter0_run = timer_start_control_ff[tsmi_pkg::BIT_COUNTER0_RUN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_general_reg_ff <= tsmi_pkg::RST_PERIOD_GENERAL;
    end else if (wr && wb_adr_i == tsmi_pkg::OFS_PERIOD_GENERAL) begin
      if (wb_sel_i[0]) begin
        period_general_reg_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        period_general_reg_ff[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer0_control_ff <= tsmi_pkg::RST_TIMER0_CONTROL;
    end else if (wr && lane0 &&
                 wb_adr_i == tsmi_pkg::OFS_TIMER0_CONTROL) begin
      timer0_control_ff <= wbyte;
    end
  end

  assign clear_on_match =
    timer0_control_ff[tsmi_pkg::BIT_COUNTER_CLEAR_SELECT_HI:tsmi_pkg::BIT_COUNTER_CLEAR_SELECT_LO] ==
    tsmi_pkg::COUNTER_CLEAR_SELECT_ON_PERIOD_MATCH;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_match_irq_enable_ff <= 1'b0;
    end else if (wr && lane0 &&
                 wb_adr_i == tsmi_pkg::OFS_TIMER0_IRQ_ENABLE) begin
      period_match_irq_enable_ff <=
        wbyte[tsmi_pkg::BIT_PERIOD_MATCH_IRQ_ENABLE];
    end
  end

  // Counter writes need both low lanes so a half value never loads
  assign counter0_load = wr && wb_sel_i[0] && wb_sel_i[1] &&
                         wb_adr_i == tsmi_pkg::OFS_COUNTER0;

  tsmi_counter #(
    .CNT_W(CNT_W)
  ) u_counter0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(counter0_run),
    .clear_on_match_i(clear_on_match),
    .period_i(period_general_reg_ff),
    .load_i(counter0_load),
    .load_val_i(wb_dat_i[CNT_W-1:0]),
    .count_o(counter0),
    .match_o(period_match)
  );

  assign counter0_o = counter0;

  // ****************************************
  // Period match flag
  // ****************************************
  assign wr_status = wr && lane0 && wb_adr_i == tsmi_pkg::OFS_TIMER0_STATUS;

  // A read arms the clear on the edge its data is captured, so the arm
  // matches what software saw; any status write with lane 0 selected disarms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clear_armed_ff <= 1'b0;
    end else if (wr_status) begin
      clear_armed_ff <= 1'b0;
    end else if (req && !ack_ff && !wb_we_i &&
                 wb_adr_i == tsmi_pkg::OFS_TIMER0_STATUS &&
                 period_match_flag_ff) begin
      clear_armed_ff <= 1'b1;
    end
  end

  // A match in the clearing cycle wins; writing 1 has no effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_match_flag_ff <= 1'b0;
    end else if (period_match) begin
      period_match_flag_ff <= 1'b1;
    end else if (wr_status && clear_armed_ff &&
                 !wbyte[tsmi_pkg::BIT_PERIOD_MATCH_FLAG]) begin
      period_match_flag_ff <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt request and mask
  // ****************************************
  assign period_match_interrupt =
    period_match && period_match_irq_enable_ff;
  assign wr_request = wr && lane0 &&
                      wb_adr_i == tsmi_pkg::OFS_IRQ_REQUEST_2H;

  // Other bits are plain storage for neighbouring sources
  for (genvar b = 0; b < tsmi_pkg::REG_W; b++) begin : g_req
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        irq_request_flags_2h_ff[b] <= tsmi_pkg::RST_IRQ_REQUEST_2H[b];
      end else if (b == tsmi_pkg::BIT_TIMER0_IRQ_REQUEST &&
                   period_match_interrupt) begin
        irq_request_flags_2h_ff[b] <= 1'b1;
      end else if (wr_request) begin
        irq_request_flags_2h_ff[b] <= wbyte[b];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_flags_2h_ff <= tsmi_pkg::RST_IRQ_MASK_2H;
    end else if (wr && lane0 && wb_adr_i == tsmi_pkg::OFS_IRQ_MASK_2H) begin
      irq_mask_flags_2h_ff <= wbyte;
    end
  end

  // Request reaches the CPU only when unmasked
  assign timer0_interrupt_o =
    irq_request_flags_2h_ff[tsmi_pkg::BIT_TIMER0_IRQ_REQUEST] &&
    !irq_mask_flags_2h_ff[tsmi_pkg::BIT_TIMER0_IRQ_MASK];

endmodule

// >>> tb/timer_start_match_irq_tb.sv
`timescale 1ns/1ps

// ****************************************
// Bench top
// ****************************************
module timer_start_match_irq_tb;
  logic clk_i, rst_i, cyc, stb, we;
  logic [7:0] adr, pins, pin_o, oe_n;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, q;
  logic ack, irq;
  logic [15:0] cnt, c;
  int err_count, checks;

  tsmi_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .port1_pin_i(pins), .port1_pin_o(pin_o), .port1_pin_oe_n_o(oe_n),
    .timer0_interrupt_o(irq), .counter0_o(cnt));
  tsmi_pin_env u_pins (.pin_o_i(pin_o), .oe_n_i(oe_n), .ext_i(8'ha5),
    .pin_o(pins));

  task end_of_test;
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until ack is sampled, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      end_of_test();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(q, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    int n;
    err_count = 0;
    checks = 0;
    rst_i <= 1'b1;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= 8'h00;
    sel <= 4'h0;
    dat <= 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h00, 32'hff);
    rd_chk(8'h04, 32'h00);
    rd_chk(8'h08, 32'h00);
    rd_chk(8'h0c, 32'hff);
    rd_chk(8'h10, 32'h00);
    rd_chk(8'h40, 32'h00);
    wr(8'h00, 8'h80);
    tick(2);
    chk(32'(oe_n), 32'h80);
    rd_chk(8'h24, 32'h80);
    // Latch drives pins 6 to 0; pin 7 still reads the outside level
    wr(8'h24, 8'h3c);
    tick(1);
    chk(32'(pin_o), 32'h3c);
    rd_chk(8'h24, 32'hbc);
    // Period 9, clear on match, match irq enabled
    bus(1'b1, 8'h14, 8'h09, 4'h3);
    wr(8'h1c, 8'h20);
    wr(8'h20, 8'h01);
    rd_chk(8'h04, 32'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'hfd);
    wr(8'h10, 8'h01);
    tick(3);
    c = cnt;
    tick(1);
    chk(32'(cnt), 32'(c + 16'h1));
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(32'(irq), 32'h1);
    if (irq !== 1'b1) begin
      end_of_test();
    end
    for (int i = 0; i < 12; i++) begin
      tick(1);
      chk(32'(cnt <= 16'h9), 32'h1);
    end
    rd_chk(8'h08, 32'h02);
    rd_chk(8'h0c, 32'hfd);
    wr(8'h10, 8'h00);
    tick(2);
    c = cnt;
    tick(5);
    chk(32'(cnt), 32'(c));
    // Clear without a prior read must not stick
    wr(8'h04, 8'h00);
    rd_chk(8'h04, 32'h01);
    wr(8'h04, 8'h00);
    rd_chk(8'h04, 32'h00);
    wr(8'h0c, 8'hff);
    tick(1);
    chk(32'(irq), 32'h0);
    wr(8'h0c, 8'hfd);
    tick(1);
    chk(32'(irq), 32'h1);
    bus(1'b1, 8'h0c, 8'h00, 4'he);
    rd_chk(8'h0c, 32'hfd);
    wr(8'h08, 8'h00);
    tick(1);
    chk(32'(irq), 32'h0);
    // Enable off: flag sets, request stays clear
    wr(8'h20, 8'h00);
    wr(8'h10, 8'h01);
    tick(30);
    chk(32'(irq), 32'h0);
    rd_chk(8'h08, 32'h00);
    rd_chk(8'h04, 32'h01);
    // Free running once the clear select leaves 001
    wr(8'h1c, 8'h00);
    tick(20);
    chk(32'(cnt > 16'h9), 32'h1);
    wr(8'h10, 8'h00);
    bus(1'b1, 8'h18, 8'h05, 4'h3);
    rd_chk(8'h18, 32'h05);
    end_of_test();
  end
endmodule

bind tsmi_top tsmi_top_chk #(.CNT_W(CNT_W), .PORT_W(PORT_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .port1_pin_i(port1_pin_i),
  .port1_pin_o(port1_pin_o), .port1_pin_oe_n_o(port1_pin_oe_n_o),
  .timer0_interrupt_o(timer0_interrupt_o), .counter0_o(counter0_o));

// >>> tb/tsmi_pin_env.sv
`timescale 1ns/1ps

// ****************************************
// Pin model outside the port
// ****************************************
module tsmi_pin_env (
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  // Released pins show the outside level
  assign pin_o = (oe_n_i & ext_i) | (~oe_n_i & pin_o_i);
endmodule

// >>> tb/tsmi_top_chk.sv
`timescale 1ns/1ps

// ****************************************
// Port checker
// ****************************************
module tsmi_top_chk #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned PORT_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tsmi_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [tsmi_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [tsmi_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [PORT_W-1:0] port1_pin_i,
  input wire logic [PORT_W-1:0] port1_pin_o,
  input wire logic [PORT_W-1:0] port1_pin_oe_n_o,
  input wire logic timer0_interrupt_o,
  input wire logic [CNT_W-1:0] counter0_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_latency_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  dir_follow_a: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00
    |=> ##1 port1_pin_oe_n_o == $past(wb_dat_i[7:0], 2))
    else $error("enable not from direction");
  dir_hold_a: assert property (
    $changed(port1_pin_oe_n_o)
    |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 8'h00))
    else $error("enable changed alone");
  stop_hold_a: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h10
    && !wb_dat_i[0] |=> ##1 ($stable(counter0_o))[*2])
    else $error("counter moves when stopped");
  start_count_a: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h10
    && wb_dat_i[0] |=> ##1 counter0_o != $past(counter0_o))
    else $error("counter idle when started");
  req_read_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h08
    && $past(timer0_interrupt_o) |-> wb_dat_o[1])
    else $error("request bit low with irq");
  mask_read_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c
    && $past(timer0_interrupt_o) |-> !wb_dat_o[1])
    else $error("mask bit high with irq");
  irq_fall_a: assert property (
    $fell(timer0_interrupt_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("irq dropped alone");
endmodule
